// >>> verilog/test_port_map.svh
// register offsets, field positions, reset values and selector codes of the
// test and aux-select group; included by the package users
`ifndef TEST_PORT_MAP_SVH
`define TEST_PORT_MAP_SVH
// register indices (byte address = 4 * index)
`define TP_IDX_PIN_VALUE     8'h34
`define TP_IDX_PROBE_STATUS  8'h35
`define TP_IDX_SELF_TEST     8'h36
`define TP_IDX_REVISION      8'h37
`define TP_IDX_AUX_SELECT    8'h38
`define TP_IDX_PIN_ENABLE    8'h40
`define TP_IDX_PROBE_SELECT  8'h41
`define TP_IDX_COMMAND       8'h42
// reset values
`define TP_RST_PIN_VALUE     8'h00
`define TP_RST_SELF_TEST     8'h40
`define TP_RST_AUX_SELECT    8'h00
`define TP_RST_PIN_ENABLE    8'h00
`define TP_RST_PROBE_SELECT  8'h00
// field positions
`define TP_BIT_IO_ENABLE     7
`define TP_BIT_NONLINEAR     6
`define TP_SELF_TEST_ON      4'h9
`define TP_SELF_TEST_OFF     4'h0
`define TP_CMD_CRC_CALC      4'h3
// revision value, arbitrary
`define TP_REVISION_CODE     8'h5A
// aux selector codes
`define AUX_TRISTATE         4'h0
`define AUX_CONVERTER        4'h1
`define AUX_CORRELATOR       4'h2
`define AUX_MIN_LEVEL        4'h4
`define AUX_INPHASE          4'h5
`define AUX_QUADRATURE       4'h6
`define AUX_HIGH             4'hA
`define AUX_LOW              4'hB
`define AUX_TX_ACTIVE        4'hC
`define AUX_RX_ACTIVE        4'hD
`define AUX_SUBCARRIER       4'hE
`define AUX_PROBE_BIT        4'hF
`endif

// >>> verilog/test_port_pkg.sv
// types shared by the test port block and its helpers
// assumes the map header is included by each user
package test_port_pkg;
    typedef logic [3:0] aux_sel_t;   // aux pin source selector
    typedef logic [7:0] byte_t;      // one register byte
endpackage

// >>> verilog/aux_pin_mux.sv
// one auxiliary pin source selector
// assumes all sources are on aclk already
`timescale 1ns/1ns
`include "test_port_map.svh"
module aux_pin_mux (
    // selector
    input  wire test_port_pkg::aux_sel_t sel,
    // level sources
    input  wire logic                    converter_bit,
    input  wire logic                    correlator_bit,
    input  wire logic                    min_level_bit,
    input  wire logic                    inphase_bit,
    input  wire logic                    quadrature_bit,
    input  wire logic                    tx_active_bit,
    input  wire logic                    rx_active_bit,
    input  wire logic                    subcarrier_bit,
    input  wire logic                    probe_bit,
    // pin drive
    output logic                         pin_out,
    output logic                         pin_oe
);
    import test_port_pkg::*;
    // source selection, reserved codes stay tri-stated
    always_comb begin
        pin_out = 1'b0;
        pin_oe  = 1'b1;
        unique case (sel)
            `AUX_CONVERTER:  pin_out = converter_bit;
            `AUX_CORRELATOR: pin_out = correlator_bit;
            `AUX_MIN_LEVEL:  pin_out = min_level_bit;
            `AUX_INPHASE:    pin_out = inphase_bit;
            `AUX_QUADRATURE: pin_out = quadrature_bit;
            `AUX_HIGH:       pin_out = 1'b1;
            `AUX_LOW:        pin_out = 1'b0;
            `AUX_TX_ACTIVE:  pin_out = tx_active_bit;
            `AUX_RX_ACTIVE:  pin_out = rx_active_bit;
            `AUX_SUBCARRIER: pin_out = subcarrier_bit;
            `AUX_PROBE_BIT:  pin_out = probe_bit;
            default:         pin_oe  = 1'b0;
        endcase
    end
endmodule // aux_pin_mux

// >>> verilog/sync_2ff.sv
// two flip-flop synchroniser, parameterised width
// assumes an asynchronous source and the block's aclk
`timescale 1ns/1ns
module sync_2ff #(
    parameter int W = 6
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // async in, synchronous out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;    // first stage, read only by q
    // two stages, cleared by reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // sync_2ff

// >>> verilog/test_port.sv
// test and debug register group with aux pin selection, AXI4-Lite slave
// assumes probe bus and status flags are on aclk; port pins are asynchronous
// Operation
// - pin_io_enable turns test port into I/O while serial_host_active is high
// - pins drive pin_drive_value where enabled
// - read shows pin levels when I/O enabled
// - probe status reads selected probe bus
// - nonlinear_receive selects nonlinear receiver mode
// - code 1001b enables self-test, 0000b disables
// - crc command starts self-test when enabled
// - revision register is read-only identification
// - aux1 bits 7:4, aux2 bits 3:0
// - codes tri-state, converter, correlator, high, low
// - code 1100 outputs transmit active flag
// - code 1101 outputs receive active flag
// - code 1110 outputs subcarrier detected flag
// - code 1111 outputs selected probe bit
// - codes 4-6 route level and samples
// - enable bits gate each pin driver
// - probe_bus_select chooses probe signal group
// - probe_bit_select chooses one probe bit
`timescale 1ns/1ns
`include "test_port_map.svh"
module test_port (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // test port pins 6..1 (bit 0 = pin 1)
    input  wire logic [5:0]  port_pin_in,
    output logic      [5:0]  port_pin_out,
    output logic      [5:0]  port_pin_oe,
    // serial host interface in use
    input  wire logic        serial_host_active,
    // probe bus join
    input  wire logic [7:0]  internal_probe_bus,
    output logic      [4:0]  probe_bus_select,
    output logic      [2:0]  probe_bit_select,
    // receiver and self-test controls
    output logic             nonlinear_receive,
    output logic             self_test_enabled,
    output logic             self_test_start,
    // aux sources
    input  wire logic        test_converter_a,
    input  wire logic        test_converter_b,
    input  wire logic        correlator_probe,
    input  wire logic        minimum_level_threshold,
    input  wire logic        inphase_sample,
    input  wire logic        quadrature_sample,
    input  wire logic        transmit_active_flag,
    input  wire logic        receive_active_flag,
    input  wire logic        subcarrier_detected,
    // aux pins
    output logic             aux1_out,
    output logic             aux1_oe,
    output logic             aux2_out,
    output logic             aux2_oe
);
    import test_port_pkg::*;

    localparam logic [1:0] RESP_OKAY   = 2'h0;  // normal answer
    localparam logic [1:0] RESP_SLVERR = 2'h2;  // unmapped address

    // register state
    byte_t      pin_value_r;      // io enable, drive value, bit 0 zero
    byte_t      self_test_r;      // nonlinear bit and self-test code
    byte_t      aux_select_r;     // two aux selectors
    logic [5:0] pin_enable_r;     // output driver enables
    byte_t      probe_select_r;   // bit select 7:5, bus select 4:0
    logic       self_test_start_r;// one-cycle start pulse

    // axi channel state
    logic [11:0] awaddr_r;        // held write address
    logic        aw_held_r;       // write address taken
    logic [31:0] wdata_r;         // held write data
    logic        wstrb0_r;        // low byte lane of held data
    logic        w_held_r;        // write data taken
    logic        bvalid_r;        // write response pending
    logic [1:0]  bresp_r;         // write response code
    logic        rvalid_r;        // read data pending
    logic [31:0] rdata_r;         // read data held
    logic [1:0]  rresp_r;         // read response code

    logic [5:0]  pin_sync;        // synchronised pin levels

    // pin inputs cross into aclk
    sync_2ff #(.W(6)) u_pin_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (port_pin_in),
        .q       (pin_sync)
    );

    // handshake decode
    wire aw_go     = s_axi_awvalid & s_axi_awready;
    wire w_go      = s_axi_wvalid & s_axi_wready;
    wire wr_fire   = aw_held_r & w_held_r & ~bvalid_r;
    wire ar_go     = s_axi_arvalid & s_axi_arready;
    wire [7:0] wr_idx = awaddr_r[9:2];
    wire [7:0] rd_idx = s_axi_araddr[9:2];
    wire wr_hit    = (awaddr_r[11:10] == 2'h0) & (awaddr_r[1:0] == 2'h0);
    wire rd_hit    = (s_axi_araddr[11:10] == 2'h0) & (s_axi_araddr[1:0] == 2'h0);
    wire wr_en     = wr_fire & wr_hit & wstrb0_r;
    wire [7:0] wb  = wdata_r[7:0];

    assign s_axi_awready = ~aw_held_r;
    assign s_axi_wready  = ~w_held_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // register write strobes
    wire we_pin_value = wr_en & (wr_idx == `TP_IDX_PIN_VALUE);
    wire we_self_test = wr_en & (wr_idx == `TP_IDX_SELF_TEST);
    wire we_aux_sel   = wr_en & (wr_idx == `TP_IDX_AUX_SELECT);
    wire we_pin_en    = wr_en & (wr_idx == `TP_IDX_PIN_ENABLE);
    wire we_probe_sel = wr_en & (wr_idx == `TP_IDX_PROBE_SELECT);
    wire we_command   = wr_en & (wr_idx == `TP_IDX_COMMAND);

    // write address decode: mapped writable or read-only indices
    wire wr_mapped = wr_hit & ((wr_idx >= `TP_IDX_PIN_VALUE & wr_idx <= `TP_IDX_AUX_SELECT)
                   | (wr_idx >= `TP_IDX_PIN_ENABLE & wr_idx <= `TP_IDX_COMMAND));

    // derived controls
    wire io_mode = pin_value_r[`TP_BIT_IO_ENABLE] & serial_host_active;
    wire st_on   = (self_test_r[3:0] == `TP_SELF_TEST_ON);

    // read mux
    wire [7:0] pin_value_rd = pin_value_r[`TP_BIT_IO_ENABLE]
                            ? {pin_value_r[7], pin_sync, 1'b0}
                            : pin_value_r;
    logic [7:0] rd_byte;
    logic       rd_ok;
    // read data selection, reserved bits read zero
    always_comb begin
        rd_byte = 8'h00;
        rd_ok   = rd_hit;
        unique case (rd_idx)
            `TP_IDX_PIN_VALUE:    rd_byte = pin_value_rd;
            `TP_IDX_PROBE_STATUS: rd_byte = internal_probe_bus;
            `TP_IDX_SELF_TEST:    rd_byte = {1'b0, self_test_r[6], 2'h0,
                                             self_test_r[3:0]};
            `TP_IDX_REVISION:     rd_byte = `TP_REVISION_CODE;
            `TP_IDX_AUX_SELECT:   rd_byte = aux_select_r;
            `TP_IDX_PIN_ENABLE:   rd_byte = {1'b0, pin_enable_r, 1'b0};
            `TP_IDX_PROBE_SELECT: rd_byte = probe_select_r;
            `TP_IDX_COMMAND:      rd_byte = 8'h00;
            default:              rd_ok   = 1'b0;
        endcase
    end

    // axi write channels: accept in either order, answer after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
            awaddr_r  <= 12'h000;
            wdata_r   <= 32'h0000_0000;
            wstrb0_r  <= 1'b0;
        end else begin
            if (aw_go) begin
                awaddr_r  <= s_axi_awaddr;
                aw_held_r <= 1'b1;
            end
            if (w_go) begin
                wdata_r  <= s_axi_wdata;
                wstrb0_r <= s_axi_wstrb[0];
                w_held_r <= 1'b1;
            end
            if (wr_fire) begin
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
            end else if (bvalid_r & s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // axi read channel: data one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= RESP_OKAY;
        end else if (ar_go) begin
            rvalid_r <= 1'b1;
            rdata_r  <= {24'h000000, rd_byte};
            rresp_r  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r & s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // control registers, reserved bits forced to zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_value_r    <= `TP_RST_PIN_VALUE;
            self_test_r    <= `TP_RST_SELF_TEST;
            aux_select_r   <= `TP_RST_AUX_SELECT;
            pin_enable_r   <= 6'h00;
            probe_select_r <= `TP_RST_PROBE_SELECT;
        end else begin
            if (we_pin_value) pin_value_r <= {wb[7:1], 1'b0};
            if (we_self_test) self_test_r <= {1'b0, wb[6], 2'h0, wb[3:0]};
            if (we_aux_sel) aux_select_r <= wb;
            if (we_pin_en) pin_enable_r <= wb[6:1];
            if (we_probe_sel) probe_select_r <= wb;
        end
    end

    // self-test start pulse on crc command while enabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            self_test_start_r <= 1'b0;
        end else begin
            self_test_start_r <= we_command & (wb[3:0] == `TP_CMD_CRC_CALC) & st_on;
        end
    end

    // control outputs
    assign nonlinear_receive = self_test_r[`TP_BIT_NONLINEAR];
    assign self_test_enabled = st_on;
    assign self_test_start   = self_test_start_r;
    assign probe_bus_select  = probe_select_r[4:0];
    assign probe_bit_select  = probe_select_r[7:5];

    // port drive in io mode only
    assign port_pin_out = io_mode ? pin_value_r[6:1] : 6'h00;
    assign port_pin_oe  = io_mode ? pin_enable_r : 6'h00;

    wire probe_bit = internal_probe_bus[probe_select_r[7:5]];

    // aux pin 1, selector bits 7:4
    aux_pin_mux u_aux1 (
        .sel            (aux_select_r[7:4]),
        .converter_bit  (test_converter_a),
        .correlator_bit (correlator_probe),
        .min_level_bit  (minimum_level_threshold),
        .inphase_bit    (inphase_sample),
        .quadrature_bit (quadrature_sample),
        .tx_active_bit  (transmit_active_flag),
        .rx_active_bit  (receive_active_flag),
        .subcarrier_bit (subcarrier_detected),
        .probe_bit      (probe_bit),
        .pin_out        (aux1_out),
        .pin_oe         (aux1_oe)
    );

    // aux pin 2, selector bits 3:0
    aux_pin_mux u_aux2 (
        .sel            (aux_select_r[3:0]),
        .converter_bit  (test_converter_b),
        .correlator_bit (correlator_probe),
        .min_level_bit  (minimum_level_threshold),
        .inphase_bit    (inphase_sample),
        .quadrature_bit (quadrature_sample),
        .tx_active_bit  (transmit_active_flag),
        .rx_active_bit  (receive_active_flag),
        .subcarrier_bit (subcarrier_detected),
        .probe_bit      (probe_bit),
        .pin_out        (aux2_out),
        .pin_oe         (aux2_oe)
    );

    // checks
    a_io_drive_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !io_mode |-> port_pin_oe == 6'h00) else $error("pins driven outside io mode");
    a_pin_enable_map: assert property (@(posedge aclk) disable iff (!aresetn)
        io_mode |-> port_pin_oe == pin_enable_r) else $error("pin enable mismatch");
    a_io_value_map: assert property (@(posedge aclk) disable iff (!aresetn)
        io_mode |-> port_pin_out == pin_value_r[6:1]) else $error("pin value wrong");
    a_pin_readback: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_go && rd_idx == `TP_IDX_PIN_VALUE && rd_hit && pin_value_r[7]
        |=> rdata_r[6:1] == $past(pin_sync)) else $error("pin readback wrong");
    a_probe_read: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_go && rd_idx == `TP_IDX_PROBE_STATUS && rd_hit
        |=> rdata_r[7:0] == $past(internal_probe_bus)) else $error("probe read wrong");
    a_selftest_start: assert property (@(posedge aclk) disable iff (!aresetn)
        self_test_start |-> $past(st_on)) else $error("self-test start while off");
    a_revision_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_go && rd_idx == `TP_IDX_REVISION && rd_hit
        |=> rdata_r == {24'h000000, `TP_REVISION_CODE}) else $error("revision wrong");
    a_aux_high: assert property (@(posedge aclk) disable iff (!aresetn)
        aux_select_r[7:4] == `AUX_HIGH |-> aux1_oe && aux1_out) else $error("aux1 high");
    a_aux_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
        aux_select_r[3:0] == 4'h3 |-> !aux2_oe) else $error("reserved code drives");
    a_aux_tx_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        aux_select_r[3:0] == `AUX_TX_ACTIVE |-> aux2_out == transmit_active_flag)
        else $error("aux2 tx flag");
    a_aux_probe_bit: assert property (@(posedge aclk) disable iff (!aresetn)
        aux_select_r[7:4] == `AUX_PROBE_BIT
        |-> aux1_out == internal_probe_bus[probe_bit_select]) else $error("probe bit");
endmodule // test_port

// >>> tb/test_port_bench.sv
// self-checking bench for the test port register group and aux pin selection
// assumes the design files and map header are compiled first; drives every port itself
`timescale 1ns/1ns
`include "test_port_map.svh"
module test_port_bench;
    import test_port_pkg::*;
    // clock, reset and bus
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    // pins, probe join, controls and aux
    logic [5:0]  port_pin_in, port_pin_out, port_pin_oe;
    logic [7:0]  internal_probe_bus;
    logic [4:0]  probe_bus_select;
    logic [2:0]  probe_bit_select;
    logic        serial_host_active, nonlinear_receive, self_test_enabled, self_test_start;
    logic        test_converter_a, test_converter_b, correlator_probe, minimum_level_threshold;
    logic        inphase_sample, quadrature_sample, transmit_active_flag, receive_active_flag;
    logic        subcarrier_detected, aux1_out, aux1_oe, aux2_out, aux2_oe;
    // scoreboard
    int          mismatches, compares, starts;
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  psel;
    logic [5:0]  en, v, pins;
    logic        io;
    logic [1:0]  e1, e2;

    test_port i_test_port (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_pin_in, .port_pin_out, .port_pin_oe,
        .serial_host_active, .internal_probe_bus, .probe_bus_select, .probe_bit_select,
        .nonlinear_receive, .self_test_enabled, .self_test_start, .test_converter_a,
        .test_converter_b, .correlator_probe, .minimum_level_threshold, .inphase_sample,
        .quadrature_sample, .transmit_active_flag, .receive_active_flag, .subcarrier_detected,
        .aux1_out, .aux1_oe, .aux2_out, .aux2_oe);

    // 125 MHz clock
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // count start pulses seen on each rising edge
    always @(posedge aclk) begin
        if (self_test_start === 1'b1) starts++;
    end

    // verdict and end of run
    task test_done;
        if (mismatches == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // compare seen against expected
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, exp);
        end
    endtask

    // bounded wait on a handshake
    task automatic guard(inout int n);
        n++;
        if (n > 200) begin
            mismatches++;
            $display("unexpected at %0t: bus handshake hung", $time);
            test_done();
        end
    endtask

    // byte address of a register index
    function automatic logic [11:0] ba(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction

    // one write: address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] dd, input logic [3:0] s,
                      output logic [1:0] rs);
        int   n;
        logic aw_ok, w_ok;
        n = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= dd;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            guard(n);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) begin
            @(posedge aclk);
            guard(n);
        end
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // one read; data and response taken at the rvalid edge
    task automatic rd(input logic [11:0] a, output logic [31:0] dd, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            guard(n);
        end while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            guard(n);
        end while (s_axi_rvalid !== 1'b1);
        dd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // full-word write expecting an okay answer
    task automatic wok(input logic [7:0] idx, input logic [7:0] dd);
        logic [1:0] rs;
        wr(ba(idx), {24'h000000, dd}, 4'hF, rs);
        check({30'h0, rs}, 32'h0, "write response");
    endtask

    // read expecting an okay answer and a given byte
    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp, input string what);
        logic [31:0] dd;
        logic [1:0]  rs;
        rd(ba(idx), dd, rs);
        check({30'h0, rs}, 32'h0, "read response");
        check(dd, {24'h000000, exp}, what);
    endtask

    // new random levels on all aux sources and the probe bus
    task shake;
        @(posedge aclk);
        {test_converter_a, test_converter_b, correlator_probe, minimum_level_threshold,
         inphase_sample, quadrature_sample, transmit_active_flag, receive_active_flag,
         subcarrier_detected} <= 9'($urandom);
        internal_probe_bus <= 8'($urandom);
        @(posedge aclk);
        #1;
    endtask

    // expected {drive, level} of one aux pin for a selector code
    function automatic logic [1:0] aux_exp(input logic [3:0] c, input logic conv);
        case (c)
            4'h1:    return {1'b1, conv};
            4'h2:    return {1'b1, correlator_probe};
            4'h4:    return {1'b1, minimum_level_threshold};
            4'h5:    return {1'b1, inphase_sample};
            4'h6:    return {1'b1, quadrature_sample};
            4'hA:    return 2'b11;
            4'hB:    return 2'b10;
            4'hC:    return {1'b1, transmit_active_flag};
            4'hD:    return {1'b1, receive_active_flag};
            4'hE:    return {1'b1, subcarrier_detected};
            4'hF:    return {1'b1, internal_probe_bus[psel[7:5]]};
            default: return 2'b00;
        endcase
    endfunction

    // watchdog well beyond the expected run length
    initial begin
        #200000;
        mismatches++;
        test_done();
    end

    // main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {port_pin_in, serial_host_active, internal_probe_bus} = '0;
        {test_converter_a, test_converter_b, correlator_probe, minimum_level_threshold} = '0;
        {inphase_sample, quadrature_sample, transmit_active_flag, receive_active_flag} = '0;
        subcarrier_detected = 1'b0;
        {mismatches, compares, starts} = '0;
        void'($urandom(32'h812E391F));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values and read-only places
        rchk(`TP_IDX_PIN_VALUE, 8'h00, "pin value reset");
        rchk(`TP_IDX_SELF_TEST, 8'h40, "self test reset");
        rchk(`TP_IDX_AUX_SELECT, 8'h00, "aux select reset");
        check({aux1_oe, aux2_oe, port_pin_oe}, 32'h0, "drivers off after reset");
        wok(`TP_IDX_REVISION, 8'hFF);
        rchk(`TP_IDX_REVISION, `TP_REVISION_CODE, "revision");
        // refused and ignored accesses
        wr(12'h800, 32'hFF, 4'hF, r);
        check({30'h0, r}, 32'h2, "write above map");
        wr(ba(`TP_IDX_AUX_SELECT) + 12'h001, 32'hAA, 4'hF, r);
        check({30'h0, r}, 32'h2, "misaligned write");
        rd(ba(8'h39), d, r);
        check({30'h0, r}, 32'h2, "unmapped read");
        wr(ba(`TP_IDX_AUX_SELECT), 32'hFF, 4'h0, r);
        rchk(`TP_IDX_AUX_SELECT, 8'h00, "no write without strobe");
        // probe selection and status
        psel = 8'($urandom);
        wok(`TP_IDX_PROBE_SELECT, psel);
        check({27'h0, probe_bus_select}, {27'h0, psel[4:0]}, "probe bus select");
        check({29'h0, probe_bit_select}, {29'h0, psel[7:5]}, "probe bit select");
        shake();
        rchk(`TP_IDX_PROBE_STATUS, internal_probe_bus, "probe status");
        // every selector code on both aux pins
        for (int i = 0; i < 32; i++) begin
            d = {24'h0, i[3:0], ~i[3:0]};
            wok(`TP_IDX_AUX_SELECT, d[7:0]);
            if (i < 16) rchk(`TP_IDX_AUX_SELECT, d[7:0], "aux select readback");
            shake();
            e1 = aux_exp(d[7:4], test_converter_a);
            e2 = aux_exp(d[3:0], test_converter_b);
            check({aux1_oe, aux1_out & aux1_oe}, {e1[1], e1[0]}, "aux1 pin");
            check({aux2_oe, aux2_out & aux2_oe}, {e2[1], e2[0]}, "aux2 pin");
        end
        // port pins in and out of I/O mode
        for (int k = 0; k < 8; k++) begin
            en = 6'($urandom);
            v = 6'($urandom);
            pins = 6'($urandom);
            io = k[1];
            @(posedge aclk);
            port_pin_in <= pins;
            serial_host_active <= k[0];
            wok(`TP_IDX_PIN_ENABLE, {1'b0, en, 1'b0});
            wok(`TP_IDX_PIN_VALUE, {io, v, 1'b1});
            rchk(`TP_IDX_PIN_VALUE, io ? {1'b1, pins, 1'b0} : {1'b0, v, 1'b0}, "pin read");
            check({26'h0, port_pin_oe}, {26'h0, (io && k[0]) ? en : 6'h00}, "pin enables");
            check({26'h0, port_pin_out}, {26'h0, (io && k[0]) ? v : 6'h00}, "pins");
        end
        // self-test enable, start and disable
        wok(`TP_IDX_SELF_TEST, 8'h09);
        check({30'h0, self_test_enabled, nonlinear_receive}, 32'h2, "self test on");
        wok(`TP_IDX_SELF_TEST, 8'hF9);
        rchk(`TP_IDX_SELF_TEST, 8'h49, "self test reserved bits");
        check({31'h0, nonlinear_receive}, 32'h1, "nonlinear mode");
        starts = 0;
        wok(`TP_IDX_COMMAND, 8'h03);
        repeat (4) @(posedge aclk);
        check(starts, 32'h1, "start pulse count");
        wok(`TP_IDX_SELF_TEST, 8'h40);
        check({31'h0, self_test_enabled}, 32'h0, "self test off");
        wok(`TP_IDX_COMMAND, 8'h03);
        repeat (4) @(posedge aclk);
        check(starts, 32'h1, "no start while disabled");
        test_done();
    end
endmodule // test_port_bench
